// ---- verilog/ballast_pkg.sv ----
// constants, types and register map of the ballast fault sequencer
package ballast_pkg;

  // clock rate and the times that the sequencer counts
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned CS_FILTER_NS     = 200;
  localparam int unsigned CS_FILTER_CYC    = (CS_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OFF_TIMEOUT_US   = 52;
  localparam int unsigned OFF_TIMEOUT_CYC  = OFF_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned OV_STOP_US       = 5;
  localparam int unsigned OV_STOP_CYC      = OV_STOP_US * CLK_MHZ;
  localparam int unsigned OV_PERSIST_MS    = 625;
  localparam int unsigned OV_PERSIST_CYC   = OV_PERSIST_MS * CLK_MHZ * 1000;
  localparam int unsigned PRERUN_MS        = 625;
  localparam int unsigned PRERUN_CYC       = PRERUN_MS * CLK_MHZ * 1000;
  localparam int unsigned BUS_RETRY_MS     = 100;
  localparam int unsigned BUS_RETRY_CYC    = BUS_RETRY_MS * CLK_MHZ * 1000;
  localparam int unsigned FAULT_RETRY_MS   = 200;
  localparam int unsigned FAULT_RETRY_CYC  = FAULT_RETRY_MS * CLK_MHZ * 1000;
  localparam int unsigned AC_FILTER_US     = 620;
  localparam int unsigned AC_FILTER_CYC    = AC_FILTER_US * CLK_MHZ;
  localparam int unsigned RET_FILTER_US    = 620;
  localparam int unsigned RET_FILTER_CYC   = RET_FILTER_US * CLK_MHZ;
  localparam int unsigned DC_FILTER_MS     = 2500;
  localparam int unsigned DC_FILTER_CYC    = DC_FILTER_MS * CLK_MHZ * 1000;
  localparam int unsigned PREHEAT_MAX_MS   = 2500;
  localparam int unsigned PREHEAT_STEPS    = 127;
  localparam int unsigned PREHEAT_STEP_CYC = PREHEAT_MAX_MS * CLK_MHZ * 1000 / PREHEAT_STEPS;
  localparam int unsigned DEAD_MIN_NS      = 1050;
  localparam int unsigned DEAD_MIN_CYC     = (DEAD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DEAD_MAX_NS      = 2100;
  localparam int unsigned DEAD_MAX_CYC     = DEAD_MAX_NS * CLK_MHZ / 1000;
  localparam int unsigned RETRY_LIMIT      = 7;

  // half-period limits of the bridge, in clock cycles
  localparam logic [15:0] RUN_HALF_MIN  = 16'h0412;  // 120 kHz
  localparam logic [15:0] RUN_HALF_MAX  = 16'h186A;  // 20 kHz
  localparam logic [15:0] PH_HALF_MIN   = 16'h0342;  // 150 kHz

  // register map and reset values
  localparam logic [7:0]  REG_PREHEAT_TIME = 8'h00;
  localparam logic [7:0]  REG_RUN_HALF     = 8'h04;
  localparam logic [7:0]  REG_PH_HALF      = 8'h08;
  localparam logic [7:0]  REG_BOOST_ON     = 8'h0C;
  localparam logic [7:0]  REG_STATUS       = 8'h10;
  localparam logic [7:0]  REG_FAULTS       = 8'h14;
  localparam logic [6:0]  RST_PREHEAT_TIME = 7'h0A;
  localparam logic [15:0] RST_RUN_HALF     = 16'h09C4;
  localparam logic [15:0] RST_PH_HALF      = 16'h04E2;
  localparam logic [15:0] RST_BOOST_ON     = 16'h03E8;

  // fault flag positions
  localparam int unsigned FLT_AC   = 0;
  localparam int unsigned FLT_DC   = 1;
  localparam int unsigned FLT_RET  = 2;
  localparam int unsigned FLT_OV   = 3;
  localparam int unsigned FLT_UV   = 4;
  localparam int unsigned FLT_OPEN = 5;

  // return current source codes
  localparam logic [1:0] RET_NOMINAL = 2'h0;
  localparam logic [1:0] RET_REDUCED = 2'h1;
  localparam logic [1:0] RET_HIGH_A  = 2'h2;
  localparam logic [1:0] RET_HIGH_B  = 2'h3;

  // comparator flags from the analog front end
  typedef struct packed {
    logic supply_lockout;
    logic supply_start;
    logic boost_over_limit;
    logic zcd_above_high;
    logic zcd_above_low;
    logic bus_above_open;
    logic bus_above_under;
    logic bus_above_95;
    logic bus_above_105;
    logic bus_above_over;
    logic lamp_sink_present;
    logic lamp_ac_over;
    logic lamp_dc_over;
    logic return_above_open;
    logic return_above_reconnect;
    logic return_above_run;
    logic floating_above_on;
    logic floating_above_off;
    logic bridge_commutated;
  } sense_t;

  typedef enum logic [6:0] {
    ST_LOCKOUT = 7'h01,
    ST_DETECT  = 7'h02,
    ST_PREHEAT = 7'h04,
    ST_PRERUN  = 7'h08,
    ST_RUN     = 7'h10,
    ST_PWRDN   = 7'h20,
    ST_LATCHED = 7'h40
  } seq_state_t;

  typedef enum logic [3:0] {
    PH_LOW  = 4'h1,
    PH_DLH  = 4'h2,
    PH_HIGH = 4'h4,
    PH_DHL  = 4'h8
  } bridge_phase_t;

endpackage

// ---- verilog/ballast_fault_sequencer.sv ----
// ballast control and protection sequencer: boost gate, half bridge, faults, retries
//
// Overview of operation
// [RL1] boost current above limit over 200 ns turns boost gate off until next cycle
// [RL2] without zero-current event 52 us after turn-off, timer starts a new cycle
// [RL3] hysteretic zero-current detector; falling crossing in off-time starts a cycle
// [RL4] bus flags decode open loop, undervoltage and overvoltage against rated level
// [RL5] run-mode overvoltage stops boost gate within 5 us; resumes below 105 percent
// [RL6] overvoltage beyond 625 ms stops inverter too, then power down and restart
// [RL7] bus undervoltage or inverter overvoltage: power down, 100 ms waits, recheck
// [RL8] at most seven bus retries skip preheat; later starts preheat again
// [RL9] preheat lasts code times step, 127 steps up to 2500 ms
// [RL10] run half period clamped to the 20 kHz to 120 kHz range
// [RL11] preheat frequency between run frequency and 150 kHz
// [RL12] lamp sense sink current before start marks an inserted lamp
// [RL13] AC lamp current over limit beyond 620 us flags end-of-life fault
// [RL14] DC lamp current over limit beyond 2500 ms flags rectifier fault
// [RL15] open filament moves threshold to reconnect level; reduced current if a lamp sink was seen, else RET_HIGH_B
// [RL16] no lamp sink before start threshold selects larger return currents
// [RL17] return level above run limit beyond 620 us in run latches a fault
// [RL18] fault: gates off, 200 ms wait, one more attempt, then latched fault
// [RL19] upper driver enabled above 10.4 V flag, disabled below 8.6 V flag
// [RL20] supply lockout holds every gate low
// [RL21] adaptive dead time between gates, 1.05 us to 2.1 us
// [RL22] run-mode fault checks start only after the 625 ms pre-run phase
// [RL23] all filters and timers are clock counters cleared when condition ends
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
module ballast_fault_sequencer #(
  parameter int unsigned OFF_TIMEOUT  = ballast_pkg::OFF_TIMEOUT_CYC,
  parameter int unsigned OV_PERSIST   = ballast_pkg::OV_PERSIST_CYC,
  parameter int unsigned PRERUN       = ballast_pkg::PRERUN_CYC,
  parameter int unsigned BUS_RETRY    = ballast_pkg::BUS_RETRY_CYC,
  parameter int unsigned FAULT_RETRY  = ballast_pkg::FAULT_RETRY_CYC,
  parameter int unsigned AC_FILTER    = ballast_pkg::AC_FILTER_CYC,
  parameter int unsigned DC_FILTER    = ballast_pkg::DC_FILTER_CYC,
  parameter int unsigned RET_FILTER   = ballast_pkg::RET_FILTER_CYC,
  parameter int unsigned PREHEAT_STEP = ballast_pkg::PREHEAT_STEP_CYC
) (
  input  wire logic                CLK,
  input  wire logic                RESET,
  input  wire ballast_pkg::sense_t SENSE,
  input  wire logic [7:0]          ADDR,
  input  wire logic [31:0]         WR_DATA,
  input  wire logic                WR_STROBE,
  input  wire logic                RD_STROBE,
  output logic [31:0]              RD_DATA,
  output logic                     BOOST_GATE_DRIVE,
  output logic                     UPPER_GATE_DRIVE,
  output logic                     LOWER_GATE_DRIVE,
  output logic [1:0]               RETURN_CURRENT_SEL,
  output logic                     RETURN_THRESHOLD_SEL
);
  import ballast_pkg::*;

  localparam int unsigned NFLT = 5;
  localparam int unsigned F_CS = 0;
  localparam int unsigned F_AC = 1;
  localparam int unsigned F_DC = 2;
  localparam int unsigned F_RET = 3;
  localparam int unsigned F_OV = 4;
  localparam int unsigned FLT_LIM [NFLT] = '{CS_FILTER_CYC, AC_FILTER, DC_FILTER, RET_FILTER, OV_PERSIST};

  sense_t        sense_meta;
  sense_t        s;
  seq_state_t    state;
  bridge_phase_t phase;
  logic [6:0]    preheat_code;
  logic [15:0]   run_half_reg;
  logic [15:0]   ph_half_reg;
  logic [15:0]   boost_on;
  logic [5:0]    fault_flags;
  logic [NFLT-1:0] fcond;
  logic [NFLT-1:0] fdone;
  logic [31:0]   fcnt [NFLT];
  logic [31:0]   wait_cnt;
  logic [31:0]   pfc_cnt;
  logic [15:0]   inv_cnt;
  logic [2:0]    bus_tries;
  logic          retry_bus;
  logic          strike;
  logic          ov_hold;
  logic          zcd_level;
  logic          zcd_prev;
  logic          boost_on_q;
  logic          float_ok;
  logic          open_seen;
  logic          sink_seen;
  logic          run_mode;
  logic          inv_active;
  logic          pfc_en;
  logic          start_ok;
  logic          bus_fault;
  logic          other_fault;
  logic          zc_event;
  logic [15:0]   half;
  logic [31:0]   preheat_target;

  // keep a half-period setting inside its frequency window
  function automatic logic [15:0] clamp_half(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp_half = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // two-flop synchroniser for all comparator flags; resets to lockout so no false start follows reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sense_meta <= '{supply_lockout: 1'b1, default: 1'b0};
      s          <= '{supply_lockout: 1'b1, default: 1'b0};
    end else begin
      sense_meta <= SENSE;
      s          <= sense_meta;
    end
  end

  // decoded conditions
  assign run_mode    = (state == ST_RUN);                                     // see RL22
  assign inv_active  = (state == ST_PREHEAT) || (state == ST_PRERUN) || run_mode;
  assign pfc_en      = inv_active && !ov_hold;
  assign start_ok    = s.supply_start && s.bus_above_open && !s.bus_above_105 // see RL4
                       && !open_seen && !s.return_above_open;                 // see RL12
  assign bus_fault   = run_mode && (!s.bus_above_under || fdone[F_OV]);       // see RL7
  assign other_fault = run_mode && (fdone[F_AC] || fdone[F_DC] || fdone[F_RET] || !s.bus_above_open);
  assign zc_event    = zcd_prev && !zcd_level && !boost_on_q;                 // see RL3
  assign half        = (state == ST_PREHEAT) ?
                       clamp_half(ph_half_reg, PH_HALF_MIN, clamp_half(run_half_reg, RUN_HALF_MIN, RUN_HALF_MAX)) :
                       clamp_half(run_half_reg, RUN_HALF_MIN, RUN_HALF_MAX); // see RL10 see RL11
  assign preheat_target = 32'(32'(preheat_code) * PREHEAT_STEP);             // see RL9

  // fault filter conditions
  assign fcond[F_CS]  = s.boost_over_limit && boost_on_q;                     // see RL1
  assign fcond[F_AC]  = run_mode && s.lamp_ac_over;                           // see RL13
  assign fcond[F_DC]  = run_mode && s.lamp_dc_over;                           // see RL14
  assign fcond[F_RET] = run_mode && s.return_above_run;                       // see RL17
  assign fcond[F_OV]  = run_mode && ov_hold;                                  // see RL6

  // saturating filter counters, cleared as soon as the condition drops
  for (genvar i = 0; i < NFLT; i++) begin : g_filter
    always_ff @(posedge CLK) begin
      if (RESET || !fcond[i]) begin
        fcnt[i] <= '0;                                                        // see RL23
      end else if (fcnt[i] != FLT_LIM[i]) begin
        fcnt[i] <= fcnt[i] + 32'h1;
      end
    end
    assign fdone[i] = (fcnt[i] == FLT_LIM[i]);
  end

  // zero-current hysteresis and edge history
  always_ff @(posedge CLK) begin
    if (RESET) begin
      zcd_level <= 1'b0;
      zcd_prev  <= 1'b0;
    end else begin
      if (s.zcd_above_high) begin
        zcd_level <= 1'b1;                                                    // see RL3
      end else if (!s.zcd_above_low) begin
        zcd_level <= 1'b0;
      end
      zcd_prev <= zcd_level;
    end
  end

  // overvoltage hold of the boost stage
  always_ff @(posedge CLK) begin
    if (RESET || !inv_active) begin
      ov_hold <= 1'b0;
    end else if (run_mode && s.bus_above_over) begin
      ov_hold <= 1'b1;                                                        // see RL5
    end else if (!s.bus_above_105) begin
      ov_hold <= 1'b0;
    end
  end

  // boost switching cycle: on-time, current limit, zero-current or timeout restart
  always_ff @(posedge CLK) begin
    if (RESET || !pfc_en || s.supply_lockout) begin
      boost_on_q <= 1'b0;
      pfc_cnt    <= '0;
    end else if (boost_on_q) begin
      if (fdone[F_CS] || pfc_cnt >= 32'(boost_on) - 32'h1) begin
        boost_on_q <= 1'b0;                                                   // see RL1
        pfc_cnt    <= '0;
      end else begin
        pfc_cnt <= pfc_cnt + 32'h1;
      end
    end else if (zc_event || pfc_cnt >= OFF_TIMEOUT - 1) begin
      boost_on_q <= 1'b1;                                                     // see RL2 see RL3
      pfc_cnt    <= '0;
    end else begin
      pfc_cnt <= pfc_cnt + 32'h1;
    end
  end

  // floating supply hysteresis for the upper driver
  always_ff @(posedge CLK) begin
    if (RESET) begin
      float_ok <= 1'b0;
    end else if (s.floating_above_on) begin
      float_ok <= 1'b1;                                                       // see RL19
    end else if (!s.floating_above_off) begin
      float_ok <= 1'b0;
    end
  end

  // half-bridge phase sequencer with adaptive dead time
  always_ff @(posedge CLK) begin
    if (RESET || !inv_active) begin
      phase   <= PH_LOW;
      inv_cnt <= '0;
    end else begin
      unique case (phase)
        PH_LOW, PH_HIGH: begin
          if (inv_cnt >= half - 16'h1) begin
            phase   <= (phase == PH_LOW) ? PH_DLH : PH_DHL;
            inv_cnt <= '0;
          end else begin
            inv_cnt <= inv_cnt + 16'h1;
          end
        end
        PH_DLH, PH_DHL: begin
          if ((inv_cnt >= 16'(DEAD_MIN_CYC - 1) && s.bridge_commutated)
              || inv_cnt >= 16'(DEAD_MAX_CYC - 1)) begin
            phase   <= (phase == PH_DLH) ? PH_HIGH : PH_LOW;                  // see RL21
            inv_cnt <= '0;
          end else begin
            inv_cnt <= inv_cnt + 16'h1;
          end
        end
      endcase
    end
  end

  // gate outputs, forced low in lockout and outside active states
  always_ff @(posedge CLK) begin
    if (RESET || s.supply_lockout) begin
      BOOST_GATE_DRIVE <= 1'b0;                                               // see RL20
      UPPER_GATE_DRIVE <= 1'b0;
      LOWER_GATE_DRIVE <= 1'b0;
    end else begin
      BOOST_GATE_DRIVE <= boost_on_q && pfc_en;
      UPPER_GATE_DRIVE <= inv_active && (phase == PH_HIGH) && float_ok;       // see RL19
      LOWER_GATE_DRIVE <= inv_active && (phase == PH_LOW);
    end
  end

  // filament detection and return current selection
  always_ff @(posedge CLK) begin
    if (RESET || s.supply_lockout) begin
      open_seen <= 1'b0;
      sink_seen <= 1'b0;
    end else begin
      if (!open_seen && s.return_above_open) begin
        open_seen <= 1'b1;                                                    // see RL15
      end else if (open_seen && !s.return_above_reconnect) begin
        open_seen <= 1'b0;
      end
      if (state == ST_DETECT && !s.supply_start && s.lamp_sink_present) begin
        sink_seen <= 1'b1;                                                    // see RL12 see RL16
      end
    end
  end

  // current source and threshold selects
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RETURN_CURRENT_SEL   <= RET_NOMINAL;
      RETURN_THRESHOLD_SEL <= 1'b0;
    end else begin
      RETURN_THRESHOLD_SEL <= open_seen;                                      // see RL15
      unique case ({!sink_seen, open_seen})
        2'b00:   RETURN_CURRENT_SEL <= RET_NOMINAL;
        2'b01:   RETURN_CURRENT_SEL <= RET_REDUCED;
        2'b10:   RETURN_CURRENT_SEL <= RET_HIGH_A;                            // see RL16
        default: RETURN_CURRENT_SEL <= RET_HIGH_B;
      endcase
    end
  end

  // operating sequence, retries and latched fault
  always_ff @(posedge CLK) begin
    if (RESET || s.supply_lockout) begin
      state     <= ST_LOCKOUT;
      wait_cnt  <= '0;
      bus_tries <= '0;
      retry_bus <= 1'b0;
      strike    <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 32'h1;
      unique case (state)
        ST_LOCKOUT: begin
          state    <= ST_DETECT;
          wait_cnt <= '0;
        end
        ST_DETECT: begin
          if (start_ok) begin
            state    <= ST_PREHEAT;
            wait_cnt <= '0;
          end
        end
        ST_PREHEAT: begin
          if (wait_cnt >= preheat_target) begin
            state    <= ST_PRERUN;                                            // see RL9
            wait_cnt <= '0;
          end
        end
        ST_PRERUN: begin
          if (wait_cnt >= PRERUN - 1) begin
            state    <= ST_RUN;                                               // see RL22
            wait_cnt <= '0;
          end
        end
        ST_RUN: begin
          if (bus_fault) begin
            state     <= ST_PWRDN;                                            // see RL7
            retry_bus <= 1'b1;
            bus_tries <= '0;
            wait_cnt  <= '0;
          end else if (other_fault) begin
            state     <= strike ? ST_LATCHED : ST_PWRDN;                      // see RL18
            strike    <= 1'b1;
            retry_bus <= 1'b0;
            wait_cnt  <= '0;
          end
        end
        ST_PWRDN: begin
          if (wait_cnt >= (retry_bus ? BUS_RETRY : FAULT_RETRY) - 1) begin
            wait_cnt <= '0;
            if (start_ok) begin
              state <= (retry_bus && bus_tries < 3'(RETRY_LIMIT)) ? ST_PRERUN : ST_PREHEAT; // see RL8
            end else if (retry_bus && bus_tries < 3'(RETRY_LIMIT)) begin
              bus_tries <= bus_tries + 3'h1;                                  // see RL8
            end
          end
        end
        ST_LATCHED: begin
          if (s.return_above_open) begin
            state    <= ST_DETECT;                                            // see RL18
            strike   <= 1'b0;
            wait_cnt <= '0;
          end
        end
      endcase
    end
  end

  // register writes and sticky fault flags; a new event wins over a clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      preheat_code <= RST_PREHEAT_TIME;
      run_half_reg <= RST_RUN_HALF;
      ph_half_reg  <= RST_PH_HALF;
      boost_on     <= RST_BOOST_ON;
      fault_flags  <= '0;
    end else begin
      if (WR_STROBE && ADDR == REG_PREHEAT_TIME) preheat_code <= WR_DATA[6:0];
      if (WR_STROBE && ADDR == REG_RUN_HALF) run_half_reg <= WR_DATA[15:0];
      if (WR_STROBE && ADDR == REG_PH_HALF) ph_half_reg <= WR_DATA[15:0];
      if (WR_STROBE && ADDR == REG_BOOST_ON) boost_on <= WR_DATA[15:0];
      fault_flags <= (fault_flags & ~((WR_STROBE && ADDR == REG_FAULTS) ? WR_DATA[5:0] : 6'h00))
                     | {!s.bus_above_open && run_mode, !s.bus_above_under && run_mode,
                        fdone[F_OV], fdone[F_RET], fdone[F_DC], fdone[F_AC]}; // see RL13 see RL14
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (RESET || !RD_STROBE) begin
      RD_DATA <= '0;
    end else begin
      unique case (ADDR)
        REG_PREHEAT_TIME: RD_DATA <= {25'h0, preheat_code};
        REG_RUN_HALF:     RD_DATA <= {16'h0, run_half_reg};
        REG_PH_HALF:      RD_DATA <= {16'h0, ph_half_reg};
        REG_BOOST_ON:     RD_DATA <= {16'h0, boost_on};
        REG_STATUS:       RD_DATA <= {16'h0, strike, bus_tries, ov_hold, float_ok, open_seen,
                                      sink_seen, boost_on_q, state};
        REG_FAULTS:       RD_DATA <= {26'h0, fault_flags};
        default:          RD_DATA <= '0;
      endcase
    end
  end

  // checks on the sequencer
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_lockout_gates_low: assert property (s.supply_lockout |=> !BOOST_GATE_DRIVE && !UPPER_GATE_DRIVE // see RL20
                                        && !LOWER_GATE_DRIVE)
    else $error("gate driven during supply lockout");
  a_limit_ends_pulse: assert property (fdone[F_CS] && boost_on_q |=> !boost_on_q ##1 !BOOST_GATE_DRIVE) // see RL1
    else $error("boost gate not cut after current limit");
  a_timeout_restart: assert property (pfc_en && !s.supply_lockout && !boost_on_q // see RL2
                                      && pfc_cnt == OFF_TIMEOUT - 1 |=> boost_on_q)
    else $error("boost timeout did not restart cycle");
  a_ov_stops_boost: assert property (run_mode && s.bus_above_over |-> ##[1:2] !BOOST_GATE_DRIVE) // see RL5
    else $error("boost gate still on in overvoltage");
  a_gates_exclusive: assert property (!(UPPER_GATE_DRIVE && LOWER_GATE_DRIVE)) // see RL21
    else $error("both bridge gates on");
  a_dead_min_kept: assert property ($fell(LOWER_GATE_DRIVE) |-> !UPPER_GATE_DRIVE [*8]) // see RL21
    else $error("dead time too short");
  a_retry_bounded: assert property (state == ST_PWRDN && retry_bus && bus_tries == 3'(RETRY_LIMIT) // see RL8
                                    |=> state != ST_PRERUN)
    else $error("preheat skipped after retry limit");
  a_prerun_quiet: assert property (state == ST_PRERUN && !s.supply_lockout // see RL22
                                   |=> state == ST_PRERUN || state == ST_RUN)
    else $error("fault check active before run mode");
  a_return_fault: assert property (fdone[F_RET] && run_mode && !s.supply_lockout // see RL17
                                   |=> state == ST_PWRDN || state == ST_LATCHED)
    else $error("return fault ignored");
  a_latched_quiet: assert property (state == ST_LATCHED |=> !BOOST_GATE_DRIVE && !LOWER_GATE_DRIVE) // see RL18
    else $error("gate active in latched fault");

  c_reach_run:     cover property (state == ST_PRERUN ##1 state == ST_RUN);
  c_skip_preheat:  cover property (state == ST_PWRDN && retry_bus ##1 state == ST_PRERUN);
  c_latched:       cover property (state == ST_RUN ##1 state == ST_LATCHED);
  c_zero_current:  cover property (zc_event ##1 boost_on_q);

endmodule

// ---- dv/ballast_plant.sv ----
// plant model: boost winding, current shunt, bridge node and floating supply
`timescale 1ns/10ps
module ballast_plant (
  input  wire logic                CLK,
  input  wire logic                NO_ZCD,
  input  wire logic                BOOST,
  input  wire logic                UPPER,
  input  wire logic                LOWER,
  input  wire ballast_pkg::sense_t BASE,
  output ballast_pkg::sense_t      SENSE
);
  import ballast_pkg::*;
  int unsigned demag = 0;
  // winding stays high while the inductor discharges, then falls through both trips
  always_ff @(posedge CLK) begin
    demag <= BOOST ? 40 : (demag != 0 ? demag - 1 : 0);
  end
  // shunt only sees current while the switch conducts
  always_comb begin
    SENSE = BASE;
    SENSE.boost_over_limit = BOOST && BASE.boost_over_limit;
    SENSE.zcd_above_high = !NO_ZCD && demag > 2;
    SENSE.zcd_above_low = !NO_ZCD && demag != 0;
    SENSE.bridge_commutated = !UPPER && !LOWER;
    SENSE.floating_above_on = 1'b1;
    SENSE.floating_above_off = 1'b1;
  end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench of the ballast fault sequencer
`timescale 1ns/10ps
module tb_top;
  import ballast_pkg::*;
  logic        CLK = 0, RESET = 1, WR_STROBE = 0, RD_STROBE = 0, no_zcd = 0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WR_DATA = 32'h0, RD_DATA, rd;
  logic        BOOST_GATE_DRIVE, UPPER_GATE_DRIVE, LOWER_GATE_DRIVE, RETURN_THRESHOLD_SEL;
  logic [1:0]  RETURN_CURRENT_SEL;
  sense_t      SENSE;
  sense_t      base = '{supply_lockout: 1'b1, supply_start: 1'b1, bus_above_open: 1'b1,
                        bus_above_under: 1'b1, bus_above_95: 1'b1, default: 1'b0};
  int          mismatches = 0, n_compared = 0, cycles = 0, n;
  always #2 CLK = ~CLK;
  ballast_fault_sequencer #(.OFF_TIMEOUT(200), .PRERUN(300), .FAULT_RETRY(300), .AC_FILTER(100), .PREHEAT_STEP(10))
  i_ballast_fault_sequencer (.CLK(CLK), .RESET(RESET), .SENSE(SENSE), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA), .BOOST_GATE_DRIVE(BOOST_GATE_DRIVE),
    .UPPER_GATE_DRIVE(UPPER_GATE_DRIVE), .LOWER_GATE_DRIVE(LOWER_GATE_DRIVE),
    .RETURN_CURRENT_SEL(RETURN_CURRENT_SEL), .RETURN_THRESHOLD_SEL(RETURN_THRESHOLD_SEL));
  ballast_plant i_ballast_plant (.CLK(CLK), .NO_ZCD(no_zcd), .BOOST(BOOST_GATE_DRIVE),
    .UPPER(UPPER_GATE_DRIVE), .LOWER(LOWER_GATE_DRIVE), .BASE(base), .SENSE(SENSE));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_reg(logic [7:0] a);
    @(posedge CLK);
    RD_STROBE <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD_STROBE <= 1'b0;
    #1 rd = RD_DATA;
  endtask
  // poll status until the wanted state shows; n counts cycles spent
  task automatic wait_state(logic [6:0] s);
    n = 0;
    do begin
      rd_reg(REG_STATUS);
      n += 2;
    end while (rd[6:0] !== s && n < 4000);
    chk("state", rd[6:0], s);
  endtask
  task automatic wait_boost(logic v);
    n = 0;
    while (BOOST_GATE_DRIVE !== v && n < 2000) begin
      @(posedge CLK);
      n++;
    end
    chk("boost_wait", 32'(n < 2000), 32'h1);
  endtask
  // reset values, unmapped read, gates low in lockout
  task automatic t_reset;
    rd_reg(REG_RUN_HALF);
    chk("run_half", rd, {16'h0, RST_RUN_HALF});
    rd_reg(8'hFC);
    chk("unmapped", rd, 32'h0);
    rd_reg(REG_STATUS);
    chk("lockout", {rd[6:0], BOOST_GATE_DRIVE, UPPER_GATE_DRIVE, LOWER_GATE_DRIVE}, {ST_LOCKOUT, 3'h0});
    $display("reset test done");
  endtask
  // open filament blocks start, reconnect, preheat code 2, pre-run
  task automatic t_start;
    @(posedge CLK);
    WR_STROBE <= 1'b1;
    ADDR <= REG_PREHEAT_TIME;
    WR_DATA <= 32'h2;
    base.return_above_open <= 1'b1;
    base.return_above_reconnect <= 1'b1;
    base.supply_lockout <= 1'b0;
    @(posedge CLK);
    WR_STROBE <= 1'b0;
    repeat (8) @(posedge CLK);
    chk("ret_sel", {RETURN_THRESHOLD_SEL, RETURN_CURRENT_SEL}, {1'b1, RET_HIGH_B});
    wait_state(ST_DETECT);
    base.return_above_open <= 1'b0;
    base.return_above_reconnect <= 1'b0;
    wait_state(ST_PREHEAT);
    wait_state(ST_PRERUN);
    chk("preheat_len", 32'(n >= 16 && n <= 24), 32'h1);
    wait_state(ST_RUN);
    chk("prerun_len", 32'(n >= 294 && n <= 306), 32'h1);
    $display("start test done");
  endtask
  // current limit, restart timer, zero-current restart
  task automatic t_boost;
    base.boost_over_limit <= 1'b1;
    wait_boost(1'b1);
    wait_boost(1'b0);
    wait_boost(1'b1);
    wait_boost(1'b0);
    chk("limit_on", 32'(n >= 50 && n <= 56), 32'h1);
    base.boost_over_limit <= 1'b0;
    no_zcd <= 1'b1;
    wait_boost(1'b1);
    wait_boost(1'b0);
    wait_boost(1'b1);
    chk("timer_off", 32'(n >= 198 && n <= 206), 32'h1);
    no_zcd <= 1'b0;
    wait_boost(1'b0);
    wait_boost(1'b1);
    chk("zcd_off", 32'(n >= 38 && n <= 48), 32'h1);
    $display("boost test done");
  endtask
  // end-of-life fault, one retry with preheat, latch, lamp removal
  task automatic t_fault;
    base.lamp_ac_over <= 1'b1;
    wait_state(ST_PWRDN);
    chk("ac_filter", 32'(n >= 100 && n <= 110), 32'h1);
    chk("gates_off", {BOOST_GATE_DRIVE, UPPER_GATE_DRIVE, LOWER_GATE_DRIVE}, 3'h0);
    rd_reg(REG_FAULTS);
    chk("eol_flag", rd[FLT_AC], 1'b1);
    @(posedge CLK);
    WR_STROBE <= 1'b1;
    ADDR <= REG_FAULTS;
    WR_DATA <= 32'h1;
    @(posedge CLK);
    WR_STROBE <= 1'b0;
    rd_reg(REG_FAULTS);
    chk("eol_clear", rd[FLT_AC], 1'b0);
    wait_state(ST_PREHEAT);
    wait_state(ST_LATCHED);
    base.return_above_open <= 1'b1;
    wait_state(ST_DETECT);
    $display("fault test done");
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    t_reset;
    t_start;
    t_boost;
    t_fault;
    stop_test;
  end
  // hang guard
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      stop_test;
    end
  end
endmodule
